/* File: core/psc_pkg.sv */
// constants, register map and sequence memory for the power state controller
// assumes one 125 MHz clock; all supply comparators arrive synchronous to it
package psc_pkg;

  // clocking: sequencing steps on a 32768 Hz tick derived from the system clock
  localparam int unsigned PSC_CLK_HZ   = 125_000_000;
  localparam int unsigned PSC_OSC_HZ   = 32768;
  localparam int unsigned PSC_TICK_CYC = PSC_CLK_HZ / PSC_OSC_HZ;
  localparam logic [11:0] PSC_TICK_LAST = 12'(PSC_TICK_CYC - 1);

  // register map (byte addresses)
  localparam logic [3:0] PSC_ADDR_CTRL     = 4'h0;
  localparam logic [3:0] PSC_ADDR_STATUS   = 4'h4;
  localparam logic [3:0] PSC_ADDR_RESOURCE = 4'h8;
  localparam logic [3:0] PSC_ADDR_FLAG     = 4'hc;

  // control register fields
  localparam int PSC_CTRL_ON    = 0;
  localparam int PSC_CTRL_OFF   = 1;
  localparam int PSC_CTRL_WAKE  = 2;
  localparam int PSC_CTRL_SLEEP = 3;
  localparam int PSC_CTRL_CHK_LO = 4;
  localparam int PSC_CTRL_MASK  = 6;
  localparam logic [1:0] PSC_CHK_RESET = 2'h0;

  // axi responses
  localparam logic [1:0] PSC_RESP_OKAY   = 2'h0;
  localparam logic [1:0] PSC_RESP_SLVERR = 2'h2;

  // resources: 8, two mode bits each
  localparam int          PSC_NRES        = 8;
  localparam logic [15:0] PSC_RES_DEFAULT = 16'h0000;
  localparam logic [1:0]  PSC_MODE_OFF    = 2'h0;
  localparam logic [1:0]  PSC_MODE_ON     = 2'h1;
  localparam logic [1:0]  PSC_MODE_LP     = 2'h2;
  localparam logic [7:0]  PSC_LINK_SRC    = 8'h08;
  localparam int          PSC_LINK_DST    = 5;

  typedef enum logic [2:0] {
    PSC_PS_NOSUP  = 3'b000,
    PSC_PS_BACKUP = 3'b001,
    PSC_PS_OFF    = 3'b010,
    PSC_PS_ACTIVE = 3'b011,
    PSC_PS_SLEEP  = 3'b100
  } psc_pstate_e;

  typedef enum logic [1:0] {
    PSC_SQ_IDLE  = 2'b00,
    PSC_SQ_CHECK = 2'b01,
    PSC_SQ_STEP  = 2'b10,
    PSC_SQ_WAIT  = 2'b11
  } psc_sqstate_e;

  typedef enum logic [1:0] {
    PSC_CHK_SKIP     = 2'b00,
    PSC_CHK_CONTINUE = 2'b01,
    PSC_CHK_HOLD_IO  = 2'b10,
    PSC_CHK_ABORT    = 2'b11
  } psc_chk_e;

  typedef struct packed {
    logic sleep;
    logic wake;
    logic off;
    logic on;
  } psc_req_s;

  // sequence word: [15] last, [14] io rail up, [12:10] resource, [9:8] mode, [7:0] wait ticks
  localparam int PSC_ROM_DEPTH = 20;
  localparam logic [4:0] PSC_ROM_LAST = 5'(PSC_ROM_DEPTH - 1);
  localparam logic [15:0] PSC_ROM [PSC_ROM_DEPTH] = '{
    16'h0102, 16'h0502, 16'h4902, 16'h0d02, 16'h9102,
    16'h1002, 16'h0c02, 16'h0802, 16'h0402, 16'h8002,
    16'h0e02, 16'h9002,
    16'h1102, 16'h8d02,
    16'h1002, 16'h0c02, 16'h0802, 16'h0402, 16'h8002,
    16'h8000
  };
  localparam logic [4:0] PSC_SEQ_OFF_TO_ACTIVE_SEQ = 5'h00;
  localparam logic [4:0] PSC_SEQ_ACTIVE_TO_OFF_SEQ = 5'h05;
  localparam logic [4:0] PSC_SEQ_ACTIVE_TO_SLEEP_SEQ = 5'h0a;
  localparam logic [4:0] PSC_SEQ_SLEEP_TO_ACTIVE_SEQ = 5'h0c;
  localparam logic [4:0] PSC_SEQ_SLEEP_TO_OFF_SEQ = 5'h0e;

  // programmed reference signature of the sequence memory
  function automatic logic [15:0] psc_rom_sig();
    logic [15:0] acc;
    acc = 16'h0000;
    for (int i = 0; i < PSC_ROM_DEPTH; i++) begin
      acc = acc ^ PSC_ROM[i];
    end
    return acc;
  endfunction
  localparam logic [15:0] PSC_ROM_REF = psc_rom_sig();

endpackage

/* File: core/psc_power_ctrl.sv */
// power state controller: arbitration, power state machine, sequencer, axi4-lite registers
// assumes inputs synchronous to mclk_i; supply comparators are already debounced
`timescale 1ns/10ps
`default_nettype none

module psc_power_ctrl
  import psc_pkg::*;
(
  input  wire logic        mclk_i,
  input  wire logic        resetn_i,
  // axi4-lite slave
  input  wire logic [3:0]  s_axi_awaddr_i,
  input  wire logic        s_axi_awvalid_i,
  output logic             s_axi_awready_o,
  input  wire logic [31:0] s_axi_wdata_i,
  input  wire logic [3:0]  s_axi_wstrb_i,
  input  wire logic        s_axi_wvalid_i,
  output logic             s_axi_wready_o,
  output logic [1:0]       s_axi_bresp_o,
  output logic             s_axi_bvalid_o,
  input  wire logic        s_axi_bready_i,
  input  wire logic [3:0]  s_axi_araddr_i,
  input  wire logic        s_axi_arvalid_i,
  output logic             s_axi_arready_o,
  output logic [31:0]      s_axi_rdata_o,
  output logic [1:0]       s_axi_rresp_o,
  output logic             s_axi_rvalid_o,
  input  wire logic        s_axi_rready_i,
  // requests and system conditions
  input  wire logic        on_req_i,
  input  wire logic        off_req_i,
  input  wire logic        wake_req_i,
  input  wire logic        sleep_req_i,
  input  wire logic        irq_pending_i,
  input  wire logic        supply_above_por_i,
  input  wire logic        system_low_threshold_i,
  input  wire logic        system_high_threshold_i,
  input  wire logic        hot_die_i,
  input  wire logic [15:0] otp_upset_i,
  // resources and status
  output logic [7:0]       resource_on_o,
  output logic [7:0]       resource_lp_o,
  output logic             always_on_supply_o,
  output logic [2:0]       power_state_o,
  output logic             busy_o,
  output logic             otp_error_flag_o
);

  ////////////////////////////////////////////////////////////////////////////
  // declarations
  psc_pstate_e  pstate;
  psc_sqstate_e sqstate;
  psc_req_s     pend;
  psc_req_s     next_pend;
  logic [11:0]  tick_cnt;
  logic         tick;
  logic [15:0]  res_mode;
  logic [1:0]   chk_opt;
  logic         irq_mask;
  logic         otp_err;
  logic         sw_on;
  logic         sw_off;
  logic         sw_wake;
  logic         sw_sleep;
  logic         aw_held;
  logic         w_held;
  logic [3:0]   aw_addr;
  logic [31:0]  w_data;
  logic [3:0]   w_strb;
  logic         wr_go;
  logic         wr_hit;
  logic [4:0]   seq_ptr;
  logic [7:0]   wait_cnt;
  psc_pstate_e  seq_target;
  logic         seq_is_off;
  logic [4:0]   chk_idx;
  logic [15:0]  chk_acc;
  logic         hold_at_io;
  logic         halted;
  logic [15:0]  seq_word;
  logic         seq_write;
  logic         err_set;
  logic         gate_ok;
  logic         start_off;
  logic         start_on;
  logic         start_wake;
  logic         start_sleep;
  logic         pre_empt;
  logic         supply_ok;
  logic         flag_clr;
  logic         linked_on;

  ////////////////////////////////////////////////////////////////////////////
  // 32768 Hz sequencing tick
  always_ff @(posedge mclk_i) begin
    if (!resetn_i) begin
      tick_cnt <= 12'h000;
      tick     <= 1'b0;
    end else begin
      tick     <= (tick_cnt == PSC_TICK_LAST);
      tick_cnt <= (tick_cnt == PSC_TICK_LAST) ? 12'h000 : tick_cnt + 12'h001;
    end
  end

  ////////////////////////////////////////////////////////////////////////////
  // axi4-lite write: address and data taken in either order, answer after both
  assign wr_go  = aw_held && w_held && !s_axi_bvalid_o;
  assign wr_hit = (aw_addr == PSC_ADDR_CTRL) || (aw_addr == PSC_ADDR_RESOURCE) ||
                  (aw_addr == PSC_ADDR_FLAG) || (aw_addr == PSC_ADDR_STATUS);

  always_ff @(posedge mclk_i) begin
    if (!resetn_i) begin
      aw_held         <= 1'b0;
      w_held          <= 1'b0;
      aw_addr         <= 4'h0;
      w_data          <= 32'h0000_0000;
      w_strb          <= 4'h0;
      s_axi_awready_o <= 1'b0;
      s_axi_wready_o  <= 1'b0;
      s_axi_bvalid_o  <= 1'b0;
      s_axi_bresp_o   <= PSC_RESP_OKAY;
    end else begin
      s_axi_awready_o <= !aw_held && !(s_axi_awvalid_i && s_axi_awready_o);
      s_axi_wready_o  <= !w_held && !(s_axi_wvalid_i && s_axi_wready_o);
      if (s_axi_awvalid_i && s_axi_awready_o) begin
        aw_held <= 1'b1;
        aw_addr <= {s_axi_awaddr_i[3:2], 2'b00};
      end
      if (s_axi_wvalid_i && s_axi_wready_o) begin
        w_held <= 1'b1;
        w_data <= s_axi_wdata_i;
        w_strb <= s_axi_wstrb_i;
      end
      if (wr_go) begin
        aw_held        <= 1'b0;
        w_held         <= 1'b0;
        s_axi_bvalid_o <= 1'b1;
        s_axi_bresp_o  <= wr_hit ? PSC_RESP_OKAY : PSC_RESP_SLVERR;
      end else if (s_axi_bvalid_o && s_axi_bready_i) begin
        s_axi_bvalid_o <= 1'b0;
      end
    end
  end

  ////////////////////////////////////////////////////////////////////////////
  // control register; request bits are write pulses, not stored
  always_ff @(posedge mclk_i) begin
    if (!resetn_i) begin
      chk_opt  <= PSC_CHK_RESET;
      irq_mask <= 1'b1;
      sw_on    <= 1'b0;
      sw_off   <= 1'b0;
      sw_wake  <= 1'b0;
      sw_sleep <= 1'b0;
      flag_clr <= 1'b0;
    end else begin
      sw_on    <= 1'b0;
      sw_off   <= 1'b0;
      sw_wake  <= 1'b0;
      sw_sleep <= 1'b0;
      flag_clr <= 1'b0;
      if (wr_go && aw_addr == PSC_ADDR_CTRL && w_strb[0]) begin
        sw_on    <= w_data[PSC_CTRL_ON];
        sw_off   <= w_data[PSC_CTRL_OFF];
        sw_wake  <= w_data[PSC_CTRL_WAKE];
        sw_sleep <= w_data[PSC_CTRL_SLEEP];
        chk_opt  <= w_data[PSC_CTRL_CHK_LO +: 2];
        irq_mask <= w_data[PSC_CTRL_MASK];
      end
      if (wr_go && aw_addr == PSC_ADDR_FLAG && w_strb[0]) begin
        flag_clr <= w_data[0];
      end
    end
  end

  // memory-error flag: write one to clear, a new error in the same cycle wins
  always_ff @(posedge mclk_i) begin
    if (!resetn_i) begin
      otp_err <= 1'b0;
    end else begin
      otp_err <= err_set || (otp_err && !flag_clr);
    end
  end

  ////////////////////////////////////////////////////////////////////////////
  // axi4-lite read: one cycle after the address is taken
  always_ff @(posedge mclk_i) begin
    if (!resetn_i) begin
      s_axi_arready_o <= 1'b0;
      s_axi_rvalid_o  <= 1'b0;
      s_axi_rdata_o   <= 32'h0000_0000;
      s_axi_rresp_o   <= PSC_RESP_OKAY;
    end else begin
      s_axi_arready_o <= !s_axi_rvalid_o && !(s_axi_arvalid_i && s_axi_arready_o);
      if (s_axi_arvalid_i && s_axi_arready_o) begin
        s_axi_rvalid_o <= 1'b1;
        s_axi_rresp_o  <= PSC_RESP_OKAY;
        case ({s_axi_araddr_i[3:2], 2'b00})
          PSC_ADDR_CTRL:     s_axi_rdata_o <= {25'h0, irq_mask, chk_opt, 4'h0};
          PSC_ADDR_STATUS:   s_axi_rdata_o <= {26'h0, halted, busy_o, 1'b0, pstate};
          PSC_ADDR_RESOURCE: s_axi_rdata_o <= {16'h0, res_mode};
          PSC_ADDR_FLAG:     s_axi_rdata_o <= {31'h0, otp_err};
          default: begin
            s_axi_rdata_o <= 32'h0000_0000;
            s_axi_rresp_o <= PSC_RESP_SLVERR;
          end
        endcase
      end else if (s_axi_rvalid_o && s_axi_rready_i) begin
        s_axi_rvalid_o <= 1'b0;
      end
    end
  end

  ////////////////////////////////////////////////////////////////////////////
  // arbitration: off first and ungated, then on, wake, sleep
  assign supply_ok = supply_above_por_i && system_low_threshold_i;
  assign gate_ok   = system_high_threshold_i && !hot_die_i;
  assign start_off = pend.off && (pstate == PSC_PS_ACTIVE || pstate == PSC_PS_SLEEP);
  assign start_on  = !pend.off && pend.on && pstate == PSC_PS_OFF && gate_ok;
  assign start_wake  = !pend.off && pend.wake && pstate == PSC_PS_SLEEP;
  assign start_sleep = !pend.off && pend.sleep && pstate == PSC_PS_ACTIVE &&
                       !irq_pending_i && !(otp_err && !irq_mask);
  assign pre_empt  = pend.off && !seq_is_off && sqstate != PSC_SQ_IDLE &&
                     pstate != PSC_PS_OFF;

  // requests stay pending while a sequence runs, except an off that pre-empts it; arrival beats consumption
  always_comb begin
    next_pend = pend;
    if (sqstate == PSC_SQ_IDLE && supply_ok) begin
      if (start_off || pstate == PSC_PS_OFF) begin
        next_pend.off = 1'b0;
      end
      if (start_on) begin
        next_pend.on = 1'b0;
      end
      if (start_wake) begin
        next_pend.wake = 1'b0;
      end
      if (start_sleep) begin
        next_pend.sleep = 1'b0;
      end
    end
    if (pre_empt) begin
      next_pend.off = 1'b0;
    end
    next_pend.on    = next_pend.on || on_req_i || sw_on;
    next_pend.off   = next_pend.off || off_req_i || sw_off;
    next_pend.wake  = next_pend.wake || wake_req_i || sw_wake;
    next_pend.sleep = next_pend.sleep || sleep_req_i || sw_sleep;
  end

  always_ff @(posedge mclk_i) begin
    if (!resetn_i) begin
      pend <= '0;
    end else begin
      pend <= next_pend;
    end
  end

  ////////////////////////////////////////////////////////////////////////////
  // power state machine and sequencer
  assign seq_word  = PSC_ROM[seq_ptr];
  assign seq_write = sqstate == PSC_SQ_STEP && tick;

  always_ff @(posedge mclk_i) begin
    if (!resetn_i) begin
      pstate     <= PSC_PS_NOSUP;
      sqstate    <= PSC_SQ_IDLE;
      seq_ptr    <= 5'h00;
      wait_cnt   <= 8'h00;
      seq_target <= PSC_PS_OFF;
      seq_is_off <= 1'b0;
      chk_idx    <= 5'h00;
      chk_acc    <= 16'h0000;
      hold_at_io <= 1'b0;
      halted     <= 1'b0;
      err_set    <= 1'b0;
    end else begin
      err_set <= 1'b0;
      if (!supply_above_por_i) begin
        pstate  <= PSC_PS_NOSUP;
        sqstate <= PSC_SQ_IDLE;
      end else if (!system_low_threshold_i) begin
        pstate  <= PSC_PS_BACKUP;
        sqstate <= PSC_SQ_IDLE;
      end else if (pstate == PSC_PS_NOSUP || pstate == PSC_PS_BACKUP) begin
        pstate <= PSC_PS_OFF;
        halted <= 1'b0;
      end else if (pre_empt) begin
        seq_ptr    <= (pstate == PSC_PS_SLEEP) ? PSC_SEQ_SLEEP_TO_OFF_SEQ : PSC_SEQ_ACTIVE_TO_OFF_SEQ;
        seq_target <= PSC_PS_OFF;
        seq_is_off <= 1'b1;
        hold_at_io <= 1'b0;
        sqstate    <= PSC_SQ_STEP;
      end else begin
        case (sqstate)
          PSC_SQ_IDLE: begin
            seq_is_off <= 1'b0;
            hold_at_io <= 1'b0;
            if (start_off) begin
              seq_ptr    <= (pstate == PSC_PS_SLEEP) ? PSC_SEQ_SLEEP_TO_OFF_SEQ : PSC_SEQ_ACTIVE_TO_OFF_SEQ;
              seq_target <= PSC_PS_OFF;
              seq_is_off <= 1'b1;
              sqstate    <= PSC_SQ_STEP;
            end else if (start_on) begin
              seq_ptr    <= PSC_SEQ_OFF_TO_ACTIVE_SEQ;
              seq_target <= PSC_PS_ACTIVE;
              halted     <= 1'b0;
              chk_idx    <= 5'h00;
              chk_acc    <= 16'h0000;
              sqstate    <= (chk_opt == PSC_CHK_SKIP) ? PSC_SQ_STEP : PSC_SQ_CHECK;
            end else if (start_wake) begin
              seq_ptr    <= gate_ok ? PSC_SEQ_SLEEP_TO_ACTIVE_SEQ : PSC_SEQ_SLEEP_TO_OFF_SEQ;
              seq_target <= gate_ok ? PSC_PS_ACTIVE : PSC_PS_OFF;
              seq_is_off <= !gate_ok;
              sqstate    <= PSC_SQ_STEP;
            end else if (start_sleep) begin
              seq_ptr    <= PSC_SEQ_ACTIVE_TO_SLEEP_SEQ;
              seq_target <= PSC_PS_SLEEP;
              sqstate    <= PSC_SQ_STEP;
            end
          end
          PSC_SQ_CHECK: begin
            // one word per clock; sensed upsets land on the first word
            chk_acc <= chk_acc ^ PSC_ROM[chk_idx] ^
                       ((chk_idx == 5'h00) ? otp_upset_i : 16'h0000);
            chk_idx <= chk_idx + 5'h01;
            if (chk_idx == PSC_ROM_LAST) begin
              if ((chk_acc ^ PSC_ROM[chk_idx]) != PSC_ROM_REF) begin
                err_set <= 1'b1;
                case (chk_opt)
                  PSC_CHK_ABORT: begin
                    sqstate <= PSC_SQ_IDLE;
                    halted  <= 1'b1;
                  end
                  PSC_CHK_HOLD_IO: begin
                    hold_at_io <= 1'b1;
                    sqstate    <= PSC_SQ_STEP;
                  end
                  default: sqstate <= PSC_SQ_STEP;
                endcase
              end else begin
                sqstate <= PSC_SQ_STEP;
              end
            end
          end
          PSC_SQ_STEP: begin
            if (tick) begin
              wait_cnt <= seq_word[7:0];
              if (hold_at_io && seq_word[14]) begin
                halted  <= 1'b1;
                sqstate <= PSC_SQ_IDLE;
              end else if (seq_word[15]) begin
                pstate  <= seq_target;
                sqstate <= PSC_SQ_IDLE;
              end else begin
                seq_ptr <= seq_ptr + 5'h01;
                sqstate <= (seq_word[7:0] == 8'h00) ? PSC_SQ_STEP : PSC_SQ_WAIT;
              end
            end
          end
          PSC_SQ_WAIT: begin
            if (tick) begin
              wait_cnt <= wait_cnt - 8'h01;
              if (wait_cnt == 8'h01) begin
                sqstate <= PSC_SQ_STEP;
              end
            end
          end
          default: sqstate <= PSC_SQ_IDLE;
        endcase
      end
    end
  end

  ////////////////////////////////////////////////////////////////////////////
  // resource mode bits: host writes or sequence accesses, cleared to default on supply loss
  always_ff @(posedge mclk_i) begin
    if (!resetn_i) begin
      res_mode <= PSC_RES_DEFAULT;
    end else if (!supply_ok) begin
      res_mode <= PSC_RES_DEFAULT;
    end else if (seq_write && !(hold_at_io && seq_word[14])) begin
      res_mode[{seq_word[12:10], 1'b0} +: 2] <= seq_word[9:8];
    end else if (wr_go && aw_addr == PSC_ADDR_RESOURCE && (&w_strb[1:0])) begin
      res_mode <= w_data[15:0];
    end
  end

  ////////////////////////////////////////////////////////////////////////////
  // registered outputs; a kept-on source resource holds its linked rail up
  assign linked_on = |(PSC_LINK_SRC & resource_on_o);

  for (genvar i = 0; i < PSC_NRES; i++) begin : g_res
    always_ff @(posedge mclk_i) begin
      if (!resetn_i) begin
        resource_on_o[i] <= 1'b0;
        resource_lp_o[i] <= 1'b0;
      end else begin
        resource_on_o[i] <= (res_mode[2*i +: 2] == PSC_MODE_ON) ||
                            (i == PSC_LINK_DST && linked_on);
        resource_lp_o[i] <= (res_mode[2*i +: 2] == PSC_MODE_LP);
      end
    end
  end

  always_ff @(posedge mclk_i) begin
    if (!resetn_i) begin
      always_on_supply_o <= 1'b0;
      power_state_o      <= PSC_PS_NOSUP;
      busy_o             <= 1'b0;
      otp_error_flag_o   <= 1'b0;
    end else begin
      always_on_supply_o <= supply_above_por_i;
      power_state_o      <= pstate;
      busy_o             <= sqstate != PSC_SQ_IDLE;
      otp_error_flag_o   <= otp_err;
    end
  end

endmodule

`default_nettype wire

/* File: verif/psc_host_model.sv */
// host model: drives the request pins and the pending-interrupt level
// assumes the bench calls its tasks aligned to mclk_i
`timescale 1ns/10ps
`default_nettype none
module psc_host_model
  import psc_pkg::*;
(
  input  wire logic mclk_i,
  output var psc_req_s req_o,
  output logic     irq_pending_o
);
  initial begin
    req_o = '0;
    irq_pending_o = 1'b0;
  end
  // one-cycle pulse: the device has to latch it as pending
  task automatic pulse(input int k);
    @(posedge mclk_i);
    req_o[k] <= 1'b1;
    @(posedge mclk_i);
    req_o[k] <= 1'b0;
  endtask
  task automatic set_irq(input logic v);
    @(posedge mclk_i);
    irq_pending_o <= v;
  endtask
endmodule
`default_nettype wire

/* File: verif/psc_power_ctrl_sva.sv */
// assertions on the power state controller ports
// assumes one clock and a synchronous active-low reset
`timescale 1ns/10ps
`default_nettype none
module psc_power_ctrl_sva (
  input wire logic       mclk_i,
  input wire logic       resetn_i,
  input wire logic       off_req_i,
  input wire logic       supply_above_por_i,
  input wire logic       system_low_threshold_i,
  input wire logic       system_high_threshold_i,
  input wire logic [2:0] power_state_o,
  input wire logic       busy_o,
  input wire logic [7:0] resource_on_o,
  input wire logic       s_axi_bvalid_o,
  input wire logic       s_axi_bready_i,
  input wire logic       s_axi_rvalid_o,
  input wire logic       s_axi_rready_i
);
  default clocking @(posedge mclk_i); endclocking
  default disable iff (!resetn_i);
  nosup_state_a:
    assert property ((!supply_above_por_i) [*2] |=> power_state_o == 3'h0)
      else $error("no-supply");
  backup_state_a:
    assert property ((supply_above_por_i && !system_low_threshold_i) [*2]
      |=> power_state_o == 3'h1) else $error("backup missed");
  off_clear_a:
    assert property ($changed(power_state_o) && power_state_o == 3'h2 |=> resource_on_o == 8'h00)
      else $error("resource on in off");
  no_seq_a:
    assert property (power_state_o < 3'h2 && $past(power_state_o) < 3'h2 |-> !busy_o)
      else $error("sequencer runs unpowered");
  off_first_a:
    assert property (off_req_i && power_state_o >= 3'h3 |-> ##[1:8] busy_o)
      else $error("off request ignored");
  on_gate_a:
    assert property ((power_state_o == 3'h2 && !system_high_threshold_i) [*3] |-> !$rose(busy_o))
      else $error("on started at low supply");
  bresp_done_a:
    assert property (s_axi_bvalid_o && s_axi_bready_i |=> !s_axi_bvalid_o) else $error("bvalid");
  rresp_done_a:
    assert property (s_axi_rvalid_o && s_axi_rready_i |=> !s_axi_rvalid_o) else $error("rvalid");
endmodule
bind psc_power_ctrl psc_power_ctrl_sva chk_u (.mclk_i(mclk_i), .resetn_i(resetn_i),
  .off_req_i(off_req_i), .supply_above_por_i(supply_above_por_i), .busy_o(busy_o),
  .system_low_threshold_i(system_low_threshold_i), .power_state_o(power_state_o),
  .system_high_threshold_i(system_high_threshold_i), .resource_on_o(resource_on_o),
  .s_axi_bvalid_o(s_axi_bvalid_o), .s_axi_bready_i(s_axi_bready_i),
  .s_axi_rvalid_o(s_axi_rvalid_o), .s_axi_rready_i(s_axi_rready_i));
`default_nettype wire

/* File: verif/test_psc_power_ctrl.sv */
// bench: axi4-lite host tasks, supply levels and request pins via the host model
// assumes the sequencer tick and memory contents of psc_pkg
`timescale 1ns/10ps
`default_nettype none
module test_psc_power_ctrl
  import psc_pkg::*;
;
  logic mclk_i = 1'b0, resetn_i = 1'b0;
  logic [3:0] awaddr = '0, araddr = '0;
  logic awvalid = 0, wvalid = 0, bready = 0, arvalid = 0, rready = 0;
  logic por = 0, lo = 0, hi = 0, hot = 0, irq, awready, wready, bvalid, arready, rvalid;
  logic aon, busy, flag;
  logic [31:0] wdata = '0, rdata, rd;
  logic [15:0] upset = '0;
  logic [3:0] strb = '0;
  logic [1:0] bresp, rresp;
  logic [7:0] res_on, res_lp;
  logic [2:0] st;
  psc_req_s req;
  int mismatches = 0, n_compared = 0;
  always #4 mclk_i = ~mclk_i;
  psc_host_model host_u (.mclk_i(mclk_i), .req_o(req), .irq_pending_o(irq));
  psc_power_ctrl dut_u (.mclk_i(mclk_i), .resetn_i(resetn_i), .s_axi_awaddr_i(awaddr),
    .s_axi_awvalid_i(awvalid), .s_axi_awready_o(awready), .s_axi_wdata_i(wdata),
    .s_axi_wstrb_i(strb), .s_axi_wvalid_i(wvalid), .s_axi_wready_o(wready),
    .s_axi_bresp_o(bresp), .s_axi_bvalid_o(bvalid), .s_axi_bready_i(bready),
    .s_axi_araddr_i(araddr), .s_axi_arvalid_i(arvalid), .s_axi_arready_o(arready),
    .s_axi_rdata_o(rdata), .s_axi_rresp_o(rresp), .s_axi_rvalid_o(rvalid),
    .s_axi_rready_i(rready), .on_req_i(req.on), .off_req_i(req.off), .wake_req_i(req.wake),
    .sleep_req_i(req.sleep), .irq_pending_i(irq), .supply_above_por_i(por),
    .system_low_threshold_i(lo), .system_high_threshold_i(hi), .hot_die_i(hot),
    .otp_upset_i(upset), .resource_on_o(res_on), .resource_lp_o(res_lp),
    .always_on_supply_o(aon), .power_state_o(st), .busy_o(busy), .otp_error_flag_o(flag));
  //////////////////////////////////////////////////////////////////////////
  task automatic cmp(input logic [31:0] got, input logic [31:0] exp);
    n_compared++;
    if (got !== exp) begin
      mismatches++;
      $display("[FAIL] %0t got %h expected %h", $time, got, exp);
    end
  endtask
  task automatic chk_out(input logic [2:0] s, input logic b, input logic [7:0] on, lp);
    @(negedge mclk_i);
    // always-on rail follows the supply: up in every state but no-supply
    cmp({11'h000, aon, st, busy, res_on, res_lp}, {11'h000, s != 3'h0, s, b, on, lp});
    @(posedge mclk_i);
  endtask
  task automatic axw(input logic [3:0] a, input logic [31:0] d, input logic [3:0] s = 4'hf);
    logic ta, tw, done;
    logic [1:0] br;
    done = 1'b0;
    @(posedge mclk_i);
    {awaddr, wdata, strb, awvalid, wvalid, bready} <= {a, d, s, 3'h7};
    for (int n = 0; n < 99 && !done; n++) begin
      @(negedge mclk_i);
      {ta, tw, done, br} = {awvalid & awready, wvalid & wready, bvalid, bresp};
      @(posedge mclk_i);
      if (ta) awvalid <= 1'b0;
      if (tw) wvalid <= 1'b0;
    end
    bready <= 1'b0;
    cmp({29'h0, done, br}, {29'h0, 1'b1, PSC_RESP_OKAY});
  endtask
  task automatic axr(input logic [3:0] a, output logic [31:0] d);
    logic ta, done;
    logic [1:0] rr;
    done = 1'b0;
    @(posedge mclk_i);
    {araddr, arvalid, rready} <= {a, 2'h3};
    for (int n = 0; n < 99 && !done; n++) begin
      @(negedge mclk_i);
      {ta, done, d, rr} = {arvalid & arready, rvalid, rdata, rresp};
      @(posedge mclk_i);
      if (ta) arvalid <= 1'b0;
    end
    rready <= 1'b0;
    cmp({29'h0, done, rr}, {29'h0, 1'b1, PSC_RESP_OKAY});
  endtask
  // sequences last tens of thousands of clocks, so wait on busy, bounded
  task automatic wait_idle(input int lim);
    logic seen;
    int n;
    seen = 1'b0;
    for (n = 0; n < lim && !(seen && !busy); n++) begin
      @(negedge mclk_i);
      seen |= busy;
    end
    @(posedge mclk_i);
    cmp(32'(n < lim), 32'h0000_0001);
  endtask
  task automatic finish_test();
    $display("compared %0d mismatches %0d", n_compared, mismatches);
    if (mismatches == 0 && n_compared > 0) begin
      $display("Simulation passed");
    end else begin
      $display("Simulation failed");
    end
    $finish;
  endtask
  initial begin
    repeat (2) @(posedge mclk_i);
    resetn_i <= 1'b1;
    repeat (3) @(posedge mclk_i);
    chk_out(3'h0, 1'b0, 8'h00, 8'h00);
    por <= 1'b1;
    repeat (3) @(posedge mclk_i);
    chk_out(3'h1, 1'b0, 8'h00, 8'h00);
    lo <= 1'b1;
    repeat (3) @(posedge mclk_i);
    chk_out(3'h2, 1'b0, 8'h00, 8'h00);
    // control write without byte-0 strobe must leave the option field alone
    axw(PSC_ADDR_CTRL, 32'h0000_0070, 4'h0);
    axr(PSC_ADDR_CTRL, rd);
    cmp(rd, 32'h0000_0040);
    // abort option: failed check stops power-up in off, halted
    axw(PSC_ADDR_CTRL, 32'h0000_0070);
    {hi, upset} <= {1'b1, 16'h0001};
    host_u.pulse(0);
    repeat (40) @(posedge mclk_i);
    axr(PSC_ADDR_STATUS, rd);
    cmp(rd, 32'h0000_0022);
    cmp({31'h0, flag}, 32'h0000_0001);
    axw(PSC_ADDR_FLAG, 32'h0000_0001);
    axr(PSC_ADDR_FLAG, rd);
    cmp(rd, 32'h0000_0000);
    cmp({31'h0, flag}, 32'h0000_0000);
    hi <= 1'b0;
    axw(PSC_ADDR_RESOURCE, 32'h0000_0004);
    chk_out(3'h2, 1'b0, 8'h02, 8'h00);
    axw(PSC_ADDR_RESOURCE, 32'h0000_0000);
    axw(PSC_ADDR_CTRL, 32'h0000_0050);
    upset <= 16'h0001;
    host_u.pulse(0);
    repeat (50) @(posedge mclk_i);
    chk_out(3'h2, 1'b0, 8'h00, 8'h00);
    {hi, hot} <= 2'h3;
    repeat (50) @(posedge mclk_i);
    chk_out(3'h2, 1'b0, 8'h00, 8'h00);
    hot <= 1'b0;
    repeat (60) @(posedge mclk_i);
    axr(PSC_ADDR_STATUS, rd);
    cmp(rd, 32'h0000_0012);
    axr(PSC_ADDR_FLAG, rd);
    cmp(rd, 32'h0000_0001);
    cmp({31'h0, flag}, 32'h0000_0001);
    wait_idle(70000);
    chk_out(3'h3, 1'b0, 8'h3f, 8'h00);
    host_u.set_irq(1'b1);
    host_u.pulse(3);
    repeat (50) @(posedge mclk_i);
    chk_out(3'h3, 1'b0, 8'h3f, 8'h00);
    host_u.set_irq(1'b0);
    wait_idle(30000);
    chk_out(3'h4, 1'b0, 8'h07, 8'h08);
    host_u.pulse(1);
    repeat (10) @(posedge mclk_i);
    axr(PSC_ADDR_STATUS, rd);
    cmp(rd, 32'h0000_0014);
    finish_test();
  end
  initial begin
    repeat (100000) @(posedge mclk_i);
    mismatches++;
    $display("[FAIL] %0t watchdog expired", $time);
    finish_test();
  end
endmodule
`default_nettype wire
